// ---- verilog/pws_consts.svh ----
// constant offsets, field positions, reset values and counts for the pwm block
`ifndef PWS_CONSTS_SVH
`define PWS_CONSTS_SVH

`define PWS_OFF_CTRL        12'h000
`define PWS_OFF_DUTY        12'h004
`define PWS_OFF_TSEL        12'h008
`define PWS_OFF_STEER       12'h00C
`define PWS_OFF_PERIOD_BASE 12'h010
`define PWS_OFF_TCTRL_BASE  12'h01C
`define PWS_OFF_COUNT       12'h028
`define PWS_OFF_STATUS      12'h02C
`define PWS_OFF_DIR         12'h030

`define PWS_RST_CTRL        8'h00
`define PWS_RST_DUTY        8'h00
`define PWS_RST_TSEL        2'h0
`define PWS_RST_STEER       5'h01
`define PWS_RST_DIR         4'hF
`define PWS_RST_PERIOD      8'hFF
`define PWS_RST_TCTRL       3'h0

`define PWS_STEER_SYNC_BIT  4
`define PWS_STAT_PWM_BIT    0
`define PWS_STAT_STEER_LSB  1
`define PWS_STAT_SHDN_BIT   5

`define PWS_MODE_PWM_UPPER  2'h3
`define PWS_CFG_SINGLE      2'h0

`define PWS_PRE_LAST_DIV1   4'h0
`define PWS_PRE_LAST_DIV4   4'h3
`define PWS_PRE_LAST_DIV16  4'hF
`define PWS_SUB_LAST        2'h3

`endif

// ---- verilog/pws_pkg.sv ----
// types shared by the pwm steering block
`default_nettype none
package pws_pkg;

   typedef struct packed {
      logic [1:0] out_config;
      logic [1:0] duty_low;
      logic [3:0] mode;
   } pws_ctrl_type;

   typedef struct packed {
      logic       sync;
      logic [3:0] enable;
   } pws_steer_type;

   typedef struct packed {
      logic       on;
      logic [1:0] prescale;
   } pws_tcfg_type;

   typedef enum logic [2:0] {
      PWS_OUT_OFF   = 3'h1,
      PWS_OUT_STD   = 3'h2,
      PWS_OUT_STEER = 3'h4
   } pws_out_mode_type;

endpackage
`default_nettype wire

// ---- verilog/pws_timer.sv ----
// 8-bit period timer with prescaler and two-bit fine count
`timescale 1ns/1ps
`default_nettype none
`include "pws_consts.svh"

module pws_timer
   import pws_pkg::*;
#(
   parameter int CNT_W = 8
) (
   input  wire logic             clk_in,
   input  wire logic             srst_in,
   input  wire pws_tcfg_type     cfg_in,
   input  wire logic [CNT_W-1:0] period_in,
   output logic      [CNT_W+1:0] ext_count_out,
   output logic                  period_start_out
);

   logic [3:0]       pre;
   logic [1:0]       sub;
   logic [CNT_W-1:0] cnt;

   wire [3:0] pre_last = (cfg_in.prescale == 2'h0) ? `PWS_PRE_LAST_DIV1 :
                         (cfg_in.prescale == 2'h1) ? `PWS_PRE_LAST_DIV4 :
                                                     `PWS_PRE_LAST_DIV16;
   wire pre_tick = cfg_in.on && (pre == pre_last);
   wire sub_tick = pre_tick && (sub == `PWS_SUB_LAST);
   wire wrap     = sub_tick && (cnt == period_in);

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         pre <= 4'h0;
         sub <= 2'h0;
         cnt <= '0;
      end else if (cfg_in.on) begin
         pre <= pre_tick ? 4'h0 : 4'(pre + 4'h1);
         sub <= pre_tick ? 2'(sub + 2'h1) : sub; // [RULE11]
         if (wrap) begin
            cnt <= '0; // [RULE10]
         end else if (sub_tick) begin
            cnt <= CNT_W'(cnt + 1'b1);
         end
      end
   end

   assign ext_count_out    = {cnt, sub}; // [RULE11]
   assign period_start_out = wrap; // [RULE7]

endmodule
`default_nettype wire

// ---- verilog/pws_pwm_steer.sv ----
// pwm generator with timer select, duty latch, output steering and shutdown
`timescale 1ns/1ps
`default_nettype none
`include "pws_consts.svh"

// Functional notes
// RULE1 - pwm on capture pin, ten-bit duty
// RULE2 - period, duty, resolution set by registers
// RULE3 - pin driven only while direction bit clear
// RULE4 - control register zero releases the pins
// RULE5 - software sets direction then loads mode
// RULE6 - two-bit field picks one of three timers
// RULE7 - selected timer period register sets period
// RULE8 - duty is high register plus two bits
// RULE9 - high during on time, low otherwise
// RULE10 - period is on time plus off time
// RULE11 - on time moves in whole count steps; the code moves it in quarter-count steps through the two-bit fine count sub
// RULE12 - single output when mode 11, config 00
// RULE13 - four enables route signal to pins
// RULE14 - lower mode bits pick steered pin polarity
// RULE15 - shutdown only hits steering enabled pins
// RULE16 - sync clear: steering changes at write
// RULE17 - sync set: steering changes at period start
// RULE18 - period start restarts, sets high, compare clears
module pws_pwm_steer
   import pws_pkg::*;
#(
   parameter int NUM_TIMERS = 3,
   parameter int ADDR_W     = 12
) (
   input  wire logic              clk_in,
   input  wire logic              srst_in,
   input  wire logic              psel_in,
   input  wire logic              penable_in,
   input  wire logic              pwrite_in,
   input  wire logic [ADDR_W-1:0] paddr_in,
   input  wire logic [31:0]       pwdata_in,
   output logic      [31:0]       prdata_out,
   output logic                   pready_out,
   output logic                   pslverr_out,
   input  wire logic              shutdown_in,
   output logic      [3:0]        pin_level_out,
   output logic      [3:0]        pin_oe_out
);

   function automatic logic addr_at(input logic [ADDR_W-1:0] addr,
                                    input logic [ADDR_W-1:0] base,
                                    input int                idx);
      addr_at = (addr == ADDR_W'(int'(base) + 4 * idx));
   endfunction

   pws_ctrl_type     ctrl;
   logic [7:0]       duty_high;
   logic [1:0]       tsel;
   pws_steer_type    steer_pending;
   logic [3:0]       active_steer;
   logic [3:0]       dir;
   logic             shutdown_flag;
   logic [9:0]       duty_latched;
   logic             pwm_raw;
   logic [7:0]       period_reg [NUM_TIMERS];
   pws_tcfg_type     tcfg_reg   [NUM_TIMERS];
   logic [9:0]       ext_count  [NUM_TIMERS];
   logic [NUM_TIMERS-1:0] start_vec;
   logic [NUM_TIMERS-1:0] period_hit;
   logic [NUM_TIMERS-1:0] tctrl_hit;
   logic [9:0]       sel_ext;
   logic             sel_start;
   logic             sel_valid;
   logic [31:0]      timer_rdata;
   logic [31:0]      rd_data;
   logic             rd_err;
   pws_out_mode_type out_mode;

   // bus phase decode
   wire apb_first = psel_in && penable_in && !pready_out;
   wire apb_xfer  = psel_in && penable_in && pready_out;
   wire wr_en     = apb_xfer && pwrite_in;

   wire hit_ctrl   = (paddr_in == `PWS_OFF_CTRL);
   wire hit_duty   = (paddr_in == `PWS_OFF_DUTY);
   wire hit_tsel   = (paddr_in == `PWS_OFF_TSEL);
   wire hit_steer  = (paddr_in == `PWS_OFF_STEER);
   wire hit_count  = (paddr_in == `PWS_OFF_COUNT);
   wire hit_status = (paddr_in == `PWS_OFF_STATUS);
   wire hit_dir    = (paddr_in == `PWS_OFF_DIR);
   wire hit_timer  = (|period_hit) || (|tctrl_hit);

   wire wr_steer   = wr_en && hit_steer;
   wire wr_sync    = pwdata_in[`PWS_STEER_SYNC_BIT];

   // time bases
   genvar g;
   generate
      for (g = 0; g < NUM_TIMERS; g = g + 1) begin : gen_timer
         assign period_hit[g] = addr_at(paddr_in, `PWS_OFF_PERIOD_BASE, g);
         assign tctrl_hit[g]  = addr_at(paddr_in, `PWS_OFF_TCTRL_BASE, g);

         always_ff @(posedge clk_in) begin
            if (srst_in) begin
               period_reg[g] <= `PWS_RST_PERIOD;
               tcfg_reg[g]   <= `PWS_RST_TCTRL;
            end else if (wr_en && period_hit[g]) begin
               period_reg[g] <= pwdata_in[7:0]; // [RULE7]
            end else if (wr_en && tctrl_hit[g]) begin
               tcfg_reg[g]   <= pwdata_in[2:0]; // [RULE2]
            end
         end

         pws_timer #(
            .CNT_W (8)
         ) u_timer (
            .clk_in           (clk_in),
            .srst_in          (srst_in),
            .cfg_in           (tcfg_reg[g]),
            .period_in        (period_reg[g]),
            .ext_count_out    (ext_count[g]),
            .period_start_out (start_vec[g])
         );
      end
   endgenerate

   // reserved select code leaves the generator without a time base
   always_comb begin
      sel_ext   = 10'h000;
      sel_start = 1'b0;
      sel_valid = 1'b0;
      for (int i = 0; i < NUM_TIMERS; i++) begin
         if (tsel == 2'(i)) begin
            sel_ext   = ext_count[i]; // [RULE6]
            sel_start = start_vec[i];
            sel_valid = 1'b1;
         end
      end
   end

   // output mode and steering decode
   wire pwm_sel    = (ctrl.mode[3:2] == `PWS_MODE_PWM_UPPER);
   wire single_out = (ctrl.out_config == `PWS_CFG_SINGLE);

   assign out_mode = (ctrl == `PWS_RST_CTRL) ? PWS_OUT_OFF :   // [RULE4]
                     !pwm_sel                ? PWS_OUT_OFF :
                     single_out              ? PWS_OUT_STEER : // [RULE12]
                                               PWS_OUT_STD;

   wire [9:0] duty_value = {duty_high, ctrl.duty_low}; // [RULE8]
   wire [3:0] pol_vec    = {ctrl.mode[0], ctrl.mode[1], ctrl.mode[0], ctrl.mode[1]};
   wire [3:0] eff_pol    = (out_mode == PWS_OUT_STEER) ? pol_vec : 4'h0; // [RULE14]
   wire [3:0] owned      = (out_mode == PWS_OUT_STEER) ? active_steer : // [RULE13]
                           (out_mode == PWS_OUT_STD)   ? 4'h1 : 4'h0;   // [RULE1]
   wire [3:0] next_oe    = owned & ~dir; // [RULE3]
   // shutdown parks driven pins at their inactive level
   wire [3:0] next_level = next_oe & (shutdown_flag ? eff_pol :     // [RULE15]
                                      ({4{pwm_raw}} ^ eff_pol));

   // control registers
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         ctrl      <= `PWS_RST_CTRL;
         duty_high <= `PWS_RST_DUTY;
         tsel      <= `PWS_RST_TSEL;
         dir       <= `PWS_RST_DIR; // [RULE5]
      end else if (wr_en) begin
         if (hit_ctrl) begin
            ctrl <= pwdata_in[7:0]; // [RULE2]
         end else if (hit_duty) begin
            duty_high <= pwdata_in[7:0];
         end else if (hit_tsel) begin
            tsel <= pwdata_in[1:0]; // [RULE6]
         end else if (hit_dir) begin
            dir <= pwdata_in[3:0];
         end
      end
   end

   // steering: immediate write or deferred to period start
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         steer_pending <= `PWS_RST_STEER;
         active_steer  <= 4'(`PWS_RST_STEER);
      end else begin
         if (wr_steer) begin
            steer_pending <= pwdata_in[4:0];
         end
         if (wr_steer && !wr_sync) begin
            active_steer <= pwdata_in[3:0]; // [RULE16]
         end else if (sel_start && steer_pending.sync) begin
            active_steer <= steer_pending.enable; // [RULE17]
         end
      end
   end

   // sticky shutdown, write one clears, a new event wins over the clear
   wire shdn_clear = wr_en && hit_status && pwdata_in[`PWS_STAT_SHDN_BIT];

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         shutdown_flag <= 1'b0;
      end else begin
         shutdown_flag <= shutdown_in || (shutdown_flag && !shdn_clear); // [RULE15]
      end
   end

   // duty latch and compare; new duty only lands at a period boundary
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         duty_latched <= 10'h000;
         pwm_raw      <= 1'b0;
      end else begin
         if (sel_start) begin
            duty_latched <= duty_value; // [RULE18]
         end
         pwm_raw <= sel_valid && pwm_sel && (sel_ext < duty_latched); // [RULE9]
      end
   end

   // pin outputs
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         pin_oe_out    <= 4'h0;
         pin_level_out <= 4'h0;
      end else begin
         pin_oe_out    <= next_oe;
         pin_level_out <= next_level;
      end
   end

   // register read mux
   always_comb begin
      timer_rdata = 32'h0000_0000;
      for (int i = 0; i < NUM_TIMERS; i++) begin
         if (period_hit[i]) begin
            timer_rdata = {24'h00_0000, period_reg[i]};
         end else if (tctrl_hit[i]) begin
            timer_rdata = {29'h0000_0000, tcfg_reg[i]};
         end
      end
   end

   always_comb begin
      rd_data = 32'h0000_0000;
      rd_err  = 1'b0;
      if (hit_ctrl) begin
         rd_data = {24'h00_0000, ctrl};
      end else if (hit_duty) begin
         rd_data = {24'h00_0000, duty_high};
      end else if (hit_tsel) begin
         rd_data = {30'h0000_0000, tsel};
      end else if (hit_steer) begin
         rd_data = {27'h000_0000, steer_pending};
      end else if (hit_count) begin
         rd_data = {22'h00_0000, sel_ext};
      end else if (hit_status) begin
         rd_data = {26'h000_0000, shutdown_flag, active_steer, pwm_raw};
      end else if (hit_dir) begin
         rd_data = {28'h000_0000, dir};
      end else if (hit_timer) begin
         rd_data = timer_rdata;
      end else begin
         rd_err = 1'b1;
      end
   end

   // one wait state keeps read data and the error flag registered
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         pready_out  <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out  <= 32'h0000_0000;
      end else begin
         pready_out  <= apb_first;
         pslverr_out <= apb_first && rd_err;
         if (apb_first && !pwrite_in) begin
            prdata_out <= rd_data;
         end
      end
   end

   // checks
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (srst_in);

   // a mode or timer change right after the start edge may legally stop the pulse
   sequence seq_period_begin;
      (sel_start && pwm_sel && (duty_value != 10'h000)) ##1 (pwm_sel && $stable(tsel));
   endsequence

   sequence seq_steer_now;
      wr_steer && !wr_sync;
   endsequence

   property p_period_high;
      seq_period_begin |-> ##1 pwm_raw;
   endproperty

   property p_steer_now;
      seq_steer_now |=> (active_steer == $past(pwdata_in[3:0]));
   endproperty

   chk_period_goes_high : assert property (p_period_high) // [RULE18]
      else $error("output not high after period start");

   chk_duty_latch_load : assert property ( // [RULE8]
      sel_start |=> (duty_latched == $past(duty_value)))
      else $error("duty not latched at period start");

   chk_zero_duty_off : assert property ( // [RULE9]
      (duty_latched == 10'h000) [*2] |-> !pwm_raw)
      else $error("zero duty produced a pulse");

   chk_dir_blocks_pin : assert property ( // [RULE3]
      $past(dir[0]) |-> !pin_oe_out[0])
      else $error("pin driven with direction set");

   chk_zero_ctrl_release : assert property ( // [RULE4]
      (ctrl == `PWS_RST_CTRL) |=> (pin_oe_out == 4'h0))
      else $error("pins held after control cleared");

   chk_steer_immediate : assert property (p_steer_now) // [RULE16]
      else $error("steering not applied at write");

   chk_steer_deferred : assert property ( // [RULE17]
      $changed(active_steer) |-> ($past(wr_steer && !wr_sync) || $past(sel_start)))
      else $error("steering changed outside write or period start");

   chk_steer_gate_pin : assert property ( // [RULE13]
      ((out_mode == PWS_OUT_STEER) && !active_steer[1]) |=> !pin_oe_out[1])
      else $error("unsteered pin driven");

   chk_polarity_map : assert property ( // [RULE14]
      ((out_mode == PWS_OUT_STEER) && !shutdown_flag && next_oe[1])
      |=> (pin_level_out[1] == ($past(pwm_raw) ^ $past(ctrl.mode[0]))))
      else $error("steered pin polarity wrong");

   chk_shutdown_park : assert property ( // [RULE15]
      shutdown_flag |=> (((pin_level_out ^ $past(eff_pol)) & pin_oe_out) == 4'h0))
      else $error("shutdown did not park driven pins");

   chk_single_mode : assert property ( // [RULE12]
      (pwm_sel && single_out && (ctrl != `PWS_RST_CTRL)) |-> (out_mode == PWS_OUT_STEER))
      else $error("single output mode not selected");

endmodule
`default_nettype wire

// ---- tb/pws_load_model.sv ----
// load on the pwm pins: measures on time and period of the first pin
`timescale 1ns/1ps
`default_nettype none

module pws_load_model (
   input  wire logic        clk_in,
   input  wire logic [3:0]  pin_level_in,
   input  wire logic [3:0]  pin_oe_in,
   input  wire logic        arm_in,
   output logic             meas_valid_out,
   output logic [15:0]      high_out,
   output logic [15:0]      per_out
);
   logic        line;
   logic        line_q = 1'b0;
   logic [1:0]  state  = 2'h0;
   logic [15:0] high_cnt;
   logic [15:0] per_cnt;

   // pull-down on the load side, so a released pin reads low
   assign line = pin_oe_in[0] ? pin_level_in[0] : 1'b0;

   // one rise-to-rise interval per arming; later periods are ignored
   always @(posedge clk_in) begin
      line_q <= line;
      meas_valid_out <= 1'b0;
      if (!arm_in) begin
         state <= 2'h0;
      end else if (line && !line_q && state != 2'h2) begin
         if (state == 2'h0) begin
            state <= 2'h1;
            high_cnt <= 16'h0001;
            per_cnt <= 16'h0001;
         end else begin
            meas_valid_out <= 1'b1;
            high_out <= high_cnt;
            per_out <= per_cnt;
            state <= 2'h2;
         end
      end else if (state == 2'h1) begin
         per_cnt <= per_cnt + 16'h0001;
         high_cnt <= high_cnt + {15'h0000, line};
      end
   end
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench for the pwm steering block
`timescale 1ns/1ps
`default_nettype none
`include "pws_consts.svh"

module tb_top
   import pws_pkg::*;
;
   logic         clk_in, srst_in, psel, penable, pwrite, shutdown, arm;
   logic [11:0]  paddr;
   logic [31:0]  pwdata, prdata;
   logic         pready, pslverr, meas_valid;
   logic [3:0]   pin_level, pin_oe, inv, oe;
   logic [15:0]  meas_high, meas_per;
   logic [33:0]  rq[$];
   logic [31:0]  pq[$];
   logic [33:0]  re;
   logic [31:0]  pe;
   logic [31:0]  rstv [13];
   pws_ctrl_type ctl;
   int           n_fail, total_checks, t, p, d, pre, pol, en, dr, p0, per0;

   pws_pwm_steer #(.NUM_TIMERS(3), .ADDR_W(12)) i_dut (
      .clk_in(clk_in), .srst_in(srst_in), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .shutdown_in(shutdown),
      .pin_level_out(pin_level), .pin_oe_out(pin_oe));

   pws_load_model i_load (
      .clk_in(clk_in), .pin_level_in(pin_level), .pin_oe_in(pin_oe), .arm_in(arm),
      .meas_valid_out(meas_valid), .high_out(meas_high), .per_out(meas_per));

   task automatic results();
      if (n_fail == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // request held until pready is sampled high, released only after that edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] dt,
                      input logic [32:0] exp);
      int n;
      rq.push_back({!wr, exp});
      @(posedge clk_in);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= dt;
      @(posedge clk_in);
      penable <= 1'b1;
      n = 0;
      do begin @(posedge clk_in); n++; end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin n_fail++; results(); end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] dt);
      apb(1'b1, a, dt, 33'h0_0000_0000);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] v);
      apb(1'b0, a, 32'h0000_0000, {1'b0, v});
   endtask

   // settle n plus 8 cycles, then watch pins for n cycles
   task automatic hold(input int n, input logic [7:0] exp);
      repeat (n + 8) @(posedge clk_in);
      repeat (n) begin @(posedge clk_in); check({pin_oe, pin_level}, exp); end
   endtask

   task automatic measure(input logic [15:0] h, input logic [15:0] per);
      int n;
      pq.push_back({h, per});
      arm <= 1'b1;
      n = 0;
      while (pq.size() != 0 && n < 6000) begin @(posedge clk_in); n++; end
      if (pq.size() != 0) begin n_fail++; results(); end
      arm <= 1'b0;
      @(posedge clk_in);
   endtask

   task automatic wait_pin(input logic v);
      int n;
      n = 0;
      while (pin_level[0] !== v && n < 4000) begin @(posedge clk_in); n++; end
      if (pin_level[0] !== v) begin n_fail++; results(); end
   endtask

   always @(posedge clk_in) begin
      if (pready === 1'b1) begin
         if (rq.size() == 0) begin
            check(64'h0000_0000_0000_0001, 64'h0000_0000_0000_0000);
         end else begin
            re = rq.pop_front();
            check(pslverr, re[32]);
            if (re[33]) check(prdata, re[31:0]);
         end
      end
      if (meas_valid === 1'b1) begin
         if (pq.size() == 0) begin
            check(64'h0000_0000_0000_0001, 64'h0000_0000_0000_0000);
         end else begin
            pe = pq.pop_front();
            check({meas_high, meas_per}, pe);
         end
      end
   end

   initial begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end

   initial begin
      srst_in = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
      pwdata = 32'h0000_0000; shutdown = 1'b0; arm = 1'b0; n_fail = 0; total_checks = 0;
      rstv = '{32'(`PWS_RST_CTRL), 32'(`PWS_RST_DUTY), 32'(`PWS_RST_TSEL),
               32'(`PWS_RST_STEER), 32'(`PWS_RST_PERIOD), 32'(`PWS_RST_PERIOD),
               32'(`PWS_RST_PERIOD), 32'(`PWS_RST_TCTRL), 32'(`PWS_RST_TCTRL),
               32'(`PWS_RST_TCTRL), 32'h0000_0000, 32'h0000_0002, 32'(`PWS_RST_DIR)};
      void'($urandom(35932));
      repeat (4) @(posedge clk_in);
      srst_in <= 1'b0;
      @(posedge clk_in);
      for (t = 0; t < 13; t++) rd(12'(t * 4), rstv[t]);
      apb(1'b0, 12'h040, 32'h0000_0000, {1'b1, 32'h0000_0000});
      // each timer in turn, with its own prescale
      for (t = 0; t < 3; t++) begin
         p = $urandom_range(40, 8);
         d = $urandom_range((p + 1) * 4 - 1, 1);
         pre = (t == 0) ? 1 : (t == 1) ? 4 : 16;
         if (t == 0) begin p0 = p; per0 = (p + 1) * 4; end
         wr(`PWS_OFF_DIR, 32'h0000_000F);
         wr(`PWS_OFF_TSEL, 32'(t));
         wr(12'(`PWS_OFF_PERIOD_BASE + 4 * t), 32'(p));
         wr(12'(`PWS_OFF_TCTRL_BASE + 4 * t), {29'h0000_0000, 1'b1, 2'(t + t / 2)});
         ctl = '{out_config: 2'h1, duty_low: 2'(d), mode: 4'hC};
         wr(`PWS_OFF_CTRL, 32'(ctl));
         wr(`PWS_OFF_DUTY, 32'(d[9:2]));
         wr(`PWS_OFF_DIR, 32'h0000_0000);
         repeat ((p + 1) * 4 * pre + 8) @(posedge clk_in);
         check(pin_oe, 4'h1);
         measure(16'(d * pre), 16'((p + 1) * 4 * pre));
      end
      wr(`PWS_OFF_TSEL, 32'h0000_0000);
      wr(`PWS_OFF_DUTY, 32'h0000_0000);
      wr(`PWS_OFF_CTRL, 32'h0000_004C);
      hold(per0, 8'h10);
      wr(`PWS_OFF_DUTY, 32'h0000_00FF);
      wr(`PWS_OFF_CTRL, 32'h0000_007C);
      hold(per0, 8'h11);
      wr(`PWS_OFF_TSEL, 32'h0000_0003);
      hold(per0, 8'h10);
      wr(`PWS_OFF_TSEL, 32'h0000_0000);
      // every polarity, random enables and directions
      for (pol = 0; pol < 4; pol++) begin
         en = $urandom_range(15, 1);
         dr = $urandom_range(15, 0);
         inv = {pol[0], pol[1], pol[0], pol[1]};
         oe = 4'(en) & ~4'(dr);
         wr(`PWS_OFF_DIR, 32'(dr));
         wr(`PWS_OFF_STEER, 32'(en));
         wr(`PWS_OFF_DUTY, 32'h0000_0000);
         wr(`PWS_OFF_CTRL, 32'(8'h0C + pol));
         hold(per0, {oe, oe & inv});
         wr(`PWS_OFF_DUTY, 32'h0000_00FF);
         wr(`PWS_OFF_CTRL, 32'(8'h3C + pol));
         hold(per0, {oe, oe & ~inv});
      end
      shutdown <= 1'b1;
      hold(4, {oe, oe & inv});
      rd(`PWS_OFF_STATUS, {26'h000_0000, 1'b1, 4'(en), 1'b1});
      shutdown <= 1'b0;
      wr(`PWS_OFF_STATUS, 32'h0000_0020);
      rd(`PWS_OFF_STATUS, {26'h000_0000, 1'b0, 4'(en), 1'b1});
      hold(per0, {oe, oe & ~inv});
      // steering timing: immediate, then held for the next period
      wr(`PWS_OFF_DIR, 32'h0000_0000);
      wr(`PWS_OFF_STEER, 32'h0000_0001);
      wr(`PWS_OFF_CTRL, 32'h0000_000C);
      wr(`PWS_OFF_DUTY, 32'((p0 + 1) / 2));
      repeat (per0 + 8) @(posedge clk_in);
      wr(`PWS_OFF_STEER, 32'h0000_0003);
      repeat (2) @(posedge clk_in);
      check(pin_oe, 4'h3);
      wait_pin(1'b0);
      wait_pin(1'b1);
      wr(`PWS_OFF_STEER, 32'h0000_0014);
      repeat (2) @(posedge clk_in);
      check(pin_oe, 4'h3);
      repeat (per0) @(posedge clk_in);
      check(pin_oe, 4'h4);
      wr(`PWS_OFF_CTRL, 32'h0000_0000);
      hold(4, 8'h00);
      results();
   end
endmodule
`default_nettype wire
